// [chan0_cal_map.vh]
// Register map, field positions and reset values for the channel 0 bank
`ifndef CHAN0_CAL_MAP_VH
`define CHAN0_CAL_MAP_VH

// Register indices; byte address is four times the index
`define IDX_CHAN0_CONFIG        8'h09
`define IDX_CHAN0_OFFSET_UPPER  8'h0A
`define IDX_CHAN0_OFFSET_LOWER  8'h0B
`define IDX_CHAN0_GAIN_UPPER    8'h0C
`define IDX_CHAN0_GAIN_LOWER    8'h0D
`define IDX_GLOBAL_DC_BLOCK     8'h08

// Field positions
`define PHASE_MSB               15
`define PHASE_LSB               6
`define DC_OFF_BIT              2
`define MUX_MSB                 1
`define MUX_LSB                 0
`define LOWER_MSB               15
`define LOWER_LSB               8
`define DCBLK_MSB               3
`define DCBLK_LSB               0

// Reset values
`define RST_CONFIG              16'h0000
`define RST_OFFSET_UPPER        16'h0000
`define RST_OFFSET_LOWER        8'h00
`define RST_GAIN_UPPER          16'h8000
`define RST_GAIN_LOWER          8'h00
`define RST_DCBLK               4'h0

// Input select codes
`define MUX_NORMAL              2'h0
`define MUX_SHORTED             2'h1
`define MUX_TEST_POS            2'h2
`define MUX_TEST_NEG            2'h3

// Unmapped read value
`define READ_UNMAPPED           32'h00000000

`endif

// [chan0_cal_regs.v]
// Channel 0 configuration and calibration registers on Avalon-MM
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "chan0_cal_map.vh"

// How it works
// - Config 15:6 is a signed phase delay in modulator cycles, reset 0.
// - Config bits 5:3 always read back as zero.
// - Config bit 2 clear follows the global DC-block setting, set bypasses it.
// - Config 1:0 picks normal, shorted, positive or negative test input.
// - The upper offset word holds offset bits 23:8 and resets to zero.
// - The lower offset word holds offset bits 7:0 in 15:8; its 7:0 read zero.
// - The upper gain word resets to 8000h and the lower gain word to zero.
// - The 24-bit gain is unsigned, spanning 0.0 to just under 2.0.
// - The lower gain word holds gain bits 7:0 in 15:8; its 7:0 read zero.
// - The global DC-block setting is a 4-bit field in 3:0 of a shared word.
module chan0_cal_regs #(
    parameter DW = 24
) (
    // Clock and reset
    input  wire          REF_CLK,
    input  wire          RST,
    // Avalon-MM slave
    input  wire [9:0]    AVS_ADDRESS,
    input  wire          AVS_READ,
    input  wire          AVS_WRITE,
    input  wire [31:0]   AVS_WRITEDATA,
    input  wire [3:0]    AVS_BYTEENABLE,
    output reg  [31:0]   AVS_READDATA,
    output wire          AVS_WAITREQUEST,
    // Raw conversion results
    input  wire          SAMPLE_VALID,
    input  wire [DW-1:0] SAMPLE_DATA,
    // Corrected conversion results
    output wire          RESULT_VALID,
    output wire [DW-1:0] RESULT_DATA,
    // Channel controls to the analog front end and filters
    output wire [9:0]    PHASE_DELAY,
    output wire [1:0]    INPUT_SELECT,
    output wire          SHORT_INPUTS,
    output wire          TEST_POS,
    output wire          TEST_NEG,
    output wire          DC_BLOCK_ON,
    output wire [3:0]    DC_BLOCK_SETTING
);

    // Register state
    reg  [9:0]  phase_q;
    reg         dc_off_q;
    reg  [1:0]  mux_q;
    reg  [15:0] offset_hi_q;
    reg  [7:0]  offset_lo_q;
    reg  [15:0] gain_hi_q;
    reg  [7:0]  gain_lo_q;
    reg  [3:0]  dcblk_q;
    reg         ack_q;

    wire [7:0]  idx;
    wire        req;
    wire        wr_take;
    wire        rd_take;
    wire [15:0] wmask;
    wire [15:0] config_word;
    wire [15:0] cfg_rst;
    wire [15:0] cfg_n;
    wire [15:0] ocal_lo_n;
    wire [15:0] gcal_lo_n;

    // Word index from the byte address; the low two bits are ignored
    assign idx = AVS_ADDRESS[9:2];
    assign req = AVS_READ | AVS_WRITE;

    // One wait state gives every access a fixed two-cycle answer
    assign AVS_WAITREQUEST = req & ~ack_q;
    assign wr_take = AVS_WRITE & ack_q;
    assign rd_take = AVS_READ & ~ack_q;

    // Byte lanes 0 and 1 carry the sixteen register bits
    assign wmask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

    // Merge a masked write into an old sixteen-bit value
    function [15:0] merge;
        input [15:0] old_v;
        input [15:0] new_v;
        input [15:0] m;
        begin
            merge = (old_v & ~m) | (new_v & m);
        end
    endfunction

    // Reserved bits 5:3 are not stored so they read as zero
    assign config_word = {phase_q, 3'b000, dc_off_q, mux_q};

    // Next values of the written words; lower words keep only 15:8
    assign cfg_rst   = `RST_CONFIG;
    assign cfg_n     = merge(config_word, AVS_WRITEDATA[15:0], wmask);
    assign ocal_lo_n = merge({offset_lo_q, 8'h00}, AVS_WRITEDATA[15:0],
                             wmask);
    assign gcal_lo_n = merge({gain_lo_q, 8'h00}, AVS_WRITEDATA[15:0],
                             wmask);

    // Ack toggles so a held request is answered on the second edge
    always @(posedge REF_CLK) begin
        if (RST)
            ack_q <= 1'b0;
        else
            ack_q <= req & ~ack_q;
    end

    // Register writes
    always @(posedge REF_CLK) begin
        if (RST) begin
            phase_q     <= cfg_rst[`PHASE_MSB:`PHASE_LSB];
            dc_off_q    <= cfg_rst[`DC_OFF_BIT];
            mux_q       <= cfg_rst[`MUX_MSB:`MUX_LSB];
            offset_hi_q <= `RST_OFFSET_UPPER;
            offset_lo_q <= `RST_OFFSET_LOWER;
            gain_hi_q   <= `RST_GAIN_UPPER;
            gain_lo_q   <= `RST_GAIN_LOWER;
            dcblk_q     <= `RST_DCBLK;
        end else if (wr_take) begin
            case (idx)
            `IDX_CHAN0_CONFIG: begin
                phase_q  <= cfg_n[`PHASE_MSB:`PHASE_LSB];
                dc_off_q <= cfg_n[`DC_OFF_BIT];
                mux_q    <= cfg_n[`MUX_MSB:`MUX_LSB];
            end
            `IDX_CHAN0_OFFSET_UPPER: begin
                offset_hi_q <= merge(offset_hi_q, AVS_WRITEDATA[15:0],
                                     wmask);
            end
            `IDX_CHAN0_OFFSET_LOWER: begin
                offset_lo_q <= ocal_lo_n[`LOWER_MSB:`LOWER_LSB];
            end
            `IDX_CHAN0_GAIN_UPPER: begin
                gain_hi_q <= merge(gain_hi_q, AVS_WRITEDATA[15:0],
                                   wmask);
            end
            `IDX_CHAN0_GAIN_LOWER: begin
                gain_lo_q <= gcal_lo_n[`LOWER_MSB:`LOWER_LSB];
            end
            `IDX_GLOBAL_DC_BLOCK: begin
                if (AVS_BYTEENABLE[0])
                    dcblk_q <= AVS_WRITEDATA[`DCBLK_MSB:`DCBLK_LSB];
            end
            default: begin
            end
            endcase
        end
    end

    // Read data captured on the first edge, stands through the answer
    always @(posedge REF_CLK) begin
        if (RST) begin
            AVS_READDATA <= 32'h00000000;
        end else if (rd_take) begin
            case (idx)
            `IDX_CHAN0_CONFIG:
                AVS_READDATA <= {16'h0000, config_word};
            `IDX_CHAN0_OFFSET_UPPER:
                AVS_READDATA <= {16'h0000, offset_hi_q};
            `IDX_CHAN0_OFFSET_LOWER:
                AVS_READDATA <= {16'h0000, offset_lo_q, 8'h00};
            `IDX_CHAN0_GAIN_UPPER:
                AVS_READDATA <= {16'h0000, gain_hi_q};
            `IDX_CHAN0_GAIN_LOWER:
                AVS_READDATA <= {16'h0000, gain_lo_q, 8'h00};
            `IDX_GLOBAL_DC_BLOCK:
                AVS_READDATA <= {28'h0000000, dcblk_q};
            default:
                AVS_READDATA <= `READ_UNMAPPED;
            endcase
        end
    end

    // Channel controls follow the stored fields directly
    assign PHASE_DELAY      = phase_q;
    assign INPUT_SELECT     = mux_q;
    assign SHORT_INPUTS     = (mux_q == `MUX_SHORTED);
    assign TEST_POS         = (mux_q == `MUX_TEST_POS);
    assign TEST_NEG         = (mux_q == `MUX_TEST_NEG);
    // Override forces bypass; otherwise the global setting governs
    assign DC_BLOCK_ON      = ~dc_off_q & (dcblk_q != 4'h0);
    assign DC_BLOCK_SETTING = dc_off_q ? 4'h0 : dcblk_q;

    // Correction: 24-bit words assembled from upper and lower halves
    chan0_correct #(
        .DW (DW)
    ) u_correct (
        .clk       (REF_CLK),
        .rst       (RST),
        .in_valid  (SAMPLE_VALID),
        .in_data   (SAMPLE_DATA),
        .offset    ({offset_hi_q, offset_lo_q}),
        .gain      ({gain_hi_q, gain_lo_q}),
        .out_valid (RESULT_VALID),
        .out_data  (RESULT_DATA)
    );

endmodule // chan0_cal_regs
`default_nettype wire

// [chan0_cal_regs_properties.sv]
// Port assertions for the channel 0 configuration and calibration bank
`timescale 1ns/1ps
`default_nettype none
`include "chan0_cal_map.vh"
module chan0_cal_checker #(
    parameter DW = 24
) (
    // Clock and reset
    input wire logic        REF_CLK,
    input wire logic        RST,
    // Register bus
    input wire logic [9:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    // Sample path and channel controls
    input wire logic        SAMPLE_VALID,
    input wire logic        RESULT_VALID,
    input wire logic [9:0]  PHASE_DELAY,
    input wire logic [1:0]  INPUT_SELECT,
    input wire logic        SHORT_INPUTS,
    input wire logic        TEST_POS,
    input wire logic        TEST_NEG,
    input wire logic        DC_BLOCK_ON,
    input wire logic [3:0]  DC_BLOCK_SETTING
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // Accepted transfers, decoded once so the properties stay short
    wire       rd_acc = AVS_READ && !AVS_WAITREQUEST;
    wire       wr_acc = AVS_WRITE && !AVS_WAITREQUEST;
    wire [7:0] idx    = AVS_ADDRESS[9:2];
    wire       rd_cfg = rd_acc && idx == `IDX_CHAN0_CONFIG;
    sequence req_new;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence dc_write;
        wr_acc && idx == `IDX_GLOBAL_DC_BLOCK && AVS_BYTEENABLE[0];
    endsequence
    sequence cfg_write;
        wr_acc && idx == `IDX_CHAN0_CONFIG && AVS_BYTEENABLE[1:0] == 2'h3;
    endsequence
    a_wait_one: assert property (req_new |=> !AVS_WAITREQUEST)
        else $error("waitrequest held past one wait cycle");
    a_phase_read: assert property (rd_cfg |->
        AVS_READDATA[15:6] == PHASE_DELAY &&
        AVS_READDATA[1:0] == INPUT_SELECT)
        else $error("config readback disagrees with outputs");
    a_resv_zero: assert property (rd_cfg |-> AVS_READDATA[5:3] == 3'h0)
        else $error("config reserved bits not zero");
    a_dc_bypass: assert property (rd_cfg && AVS_READDATA[2] |->
        !DC_BLOCK_ON && DC_BLOCK_SETTING == 4'h0)
        else $error("dc block not bypassed");
    a_mux_decode: assert property (
        SHORT_INPUTS == (INPUT_SELECT == 2'h1) &&
        TEST_POS == (INPUT_SELECT == 2'h2) &&
        TEST_NEG == (INPUT_SELECT == 2'h3))
        else $error("input select decode wrong");
    a_lower_zero: assert property (rd_acc &&
        (idx == `IDX_CHAN0_OFFSET_LOWER || idx == `IDX_CHAN0_GAIN_LOWER)
        |-> AVS_READDATA[7:0] == 8'h00)
        else $error("lower word reserved bits not zero");
    a_cfg_write: assert property (cfg_write |=>
        PHASE_DELAY == $past(AVS_WRITEDATA[15:6]) &&
        INPUT_SELECT == $past(AVS_WRITEDATA[1:0]))
        else $error("config write not applied");
    a_dc_follow: assert property (dc_write |=>
        DC_BLOCK_ON == (DC_BLOCK_SETTING != 4'h0) &&
        (DC_BLOCK_SETTING == $past(AVS_WRITEDATA[3:0]) ||
         DC_BLOCK_SETTING == 4'h0))
        else $error("dc block setting not applied");
    a_result_pulse: assert property (SAMPLE_VALID |=> RESULT_VALID)
        else $error("result pulse missing");
    a_no_spurious: assert property (!SAMPLE_VALID |=> !RESULT_VALID)
        else $error("result pulse without sample");
    a_reset_out: assert property ($fell(RST) |->
        PHASE_DELAY == 10'h000 && INPUT_SELECT == 2'h0 &&
        DC_BLOCK_SETTING == 4'h0)
        else $error("outputs not at reset value");
endmodule // chan0_cal_checker
bind chan0_cal_regs chan0_cal_checker #(.DW(DW)) u_chk (
    .REF_CLK(REF_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .SAMPLE_VALID(SAMPLE_VALID), .RESULT_VALID(RESULT_VALID),
    .PHASE_DELAY(PHASE_DELAY), .INPUT_SELECT(INPUT_SELECT),
    .SHORT_INPUTS(SHORT_INPUTS), .TEST_POS(TEST_POS), .TEST_NEG(TEST_NEG),
    .DC_BLOCK_ON(DC_BLOCK_ON), .DC_BLOCK_SETTING(DC_BLOCK_SETTING));
`default_nettype wire

// [chan0_cal_regs_tb.sv]
// Self-checking bench for the channel 0 register bank and correction path
`timescale 1ns/1ps
`default_nettype none
`include "chan0_cal_map.vh"
module chan0_cal_regs_tb;
    logic        clk, rst, rd, wr, sv, rv, son, tpos, tneg, dcon, wreq;
    logic [9:0]  addr, phase;
    logic [31:0] wdata, rdata, q;
    logic [23:0] sdata, rdat;
    logic [1:0]  isel;
    logic [3:0]  dcset, be;
    int          err_count, n_checks, cycles, i;
    // Expected words after reset and after writing all ones
    logic [31:0] rst_v[5] = '{32'h0, 32'h0, 32'h0, 32'h8000, 32'h0};
    logic [31:0] one_v[5] = '{32'hFFC7, 32'hFFFF, 32'hFF00, 32'hFFFF,
                              32'hFF00};
    // Offset, gain, sample, expected corrected result
    logic [23:0] c_o[5] = '{24'h0, 24'h100, 24'hFFFF00, 24'h0, 24'h1};
    logic [23:0] c_g[5] = '{24'h800000, 24'h400000, 24'hFFFFFF, 24'hFFFFFF,
                            24'h800000};
    logic [23:0] c_s[5] = '{24'h123456, 24'h123456, 24'h0, 24'h7FFFFF,
                            24'h800000};
    logic [23:0] c_e[5] = '{24'h123456, 24'h0919AB, 24'h1FF, 24'h7FFFFF,
                            24'h800000};
    chan0_cal_regs #(.DW(24)) DUT (
        .REF_CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .SAMPLE_VALID(sv),
        .SAMPLE_DATA(sdata), .RESULT_VALID(rv), .RESULT_DATA(rdat),
        .PHASE_DELAY(phase), .INPUT_SELECT(isel), .SHORT_INPUTS(son),
        .TEST_POS(tpos), .TEST_NEG(tneg), .DC_BLOCK_ON(dcon),
        .DC_BLOCK_SETTING(dcset));
    // 50 MHz reference clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task end_sim;
        if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus transfer, entered just after an edge; the request stands
    // until the edge at which waitrequest is sampled low, then one idle
    // edge passes so the next call never re-raises a strobe in one step
    task bus(input logic w, input logic [7:0] x, input logic [15:0] d);
        addr <= {x, 2'b00};
        wr <= w;
        rd <= !w;
        wdata <= {16'h0000, d};
        @(posedge clk);
        while (wreq !== 1'b0)
            @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // Both calibration pairs, upper word first
    task cal(input logic [23:0] o, input logic [23:0] g);
        bus(1'b1, `IDX_CHAN0_OFFSET_UPPER, o[23:8]);
        bus(1'b1, `IDX_CHAN0_OFFSET_LOWER, {o[7:0], 8'h00});
        bus(1'b1, `IDX_CHAN0_GAIN_UPPER, g[23:8]);
        bus(1'b1, `IDX_CHAN0_GAIN_LOWER, {g[7:0], 8'h00});
    endtask
    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        {rst, rd, wr, sv, addr, wdata, sdata, err_count, n_checks, cycles} = '0;
        rst = 1'b1;
        be = 4'hF;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 5; i++) begin
            bus(1'b0, `IDX_CHAN0_CONFIG + i[7:0], 16'h0000);
            chk(q, rst_v[i]);
        end
        for (i = 0; i < 5; i++) begin
            bus(1'b1, `IDX_CHAN0_CONFIG + i[7:0], 16'hFFFF);
            bus(1'b0, `IDX_CHAN0_CONFIG + i[7:0], 16'h0000);
            chk(q, one_v[i]);
        end
        // Every input select code with a negative phase delay
        for (i = 0; i < 4; i++) begin
            bus(1'b1, `IDX_CHAN0_CONFIG, {14'h2000, i[1:0]});
            chk({phase, isel}, {10'h200, i[1:0]});
            chk({son, tpos, tneg}, {i == 1, i == 2, i == 3});
        end
        bus(1'b1, `IDX_GLOBAL_DC_BLOCK, 16'h0005);
        chk({dcon, dcset}, {1'b1, 4'h5});
        bus(1'b1, `IDX_CHAN0_CONFIG, 16'h0004);
        chk({dcon, dcset}, 5'h00);
        bus(1'b0, 8'h3F, 16'h0000);
        chk(q, 32'h0);
        // Only lane 1 enabled: the low byte of the word must survive
        be <= 4'h2;
        bus(1'b1, `IDX_CHAN0_OFFSET_UPPER, 16'h1234);
        be <= 4'hF;
        bus(1'b0, `IDX_CHAN0_OFFSET_UPPER, 16'h0000);
        chk(q, 32'h12FF);
        // Reset in mid-run brings every word back to its reset value
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 5; i++) begin
            bus(1'b0, `IDX_CHAN0_CONFIG + i[7:0], 16'h0000);
            chk(q, rst_v[i]);
        end
        chk({dcon, dcset, phase, isel}, 32'h0);
        for (i = 0; i < 5; i++) begin
            cal(c_o[i], c_g[i]);
            sv <= 1'b1;
            sdata <= c_s[i];
            @(posedge clk);
            sv <= 1'b0;
            #1;
            chk({rv, rdat}, {1'b1, c_e[i]});
            @(posedge clk);
        end
        end_sim();
    end
endmodule // chan0_cal_regs_tb
`default_nettype wire

// [chan0_correct.v]
// Offset and gain correction datapath for channel 0 conversion results
`timescale 1ns/1ps
`default_nettype none

module chan0_correct #(
    parameter DW = 24
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst,
    // Raw sample
    input  wire          in_valid,
    input  wire [DW-1:0] in_data,
    // Calibration words
    input  wire [DW-1:0] offset,
    input  wire [DW-1:0] gain,
    // Corrected sample
    output reg           out_valid,
    output reg  [DW-1:0] out_data
);

    wire signed [DW:0]     diff;
    wire signed [2*DW+1:0] prod;
    wire signed [DW+1:0]   scaled;
    wire signed [DW:0]     max_pos;
    wire signed [DW:0]     max_neg;
    reg         [DW-1:0]   sat;

    // Subtract offset one bit wider so it cannot wrap
    assign diff    = {in_data[DW-1], in_data} - {offset[DW-1], offset};
    // Gain is unsigned, 2^23 is unity, so drop 23 fraction bits
    assign prod    = diff * $signed({1'b0, gain});
    // Keep the sign bit above the kept magnitude so negatives clip low
    assign scaled  = prod[2*DW:DW-1];
    assign max_pos = {2'b00, {(DW-1){1'b1}}};
    assign max_neg = {2'b11, {(DW-1){1'b0}}};

    // Clip rather than wrap at full scale
    always @* begin
        if (scaled > $signed({max_pos[DW], max_pos}))
            sat = max_pos[DW-1:0];
        else if (scaled < $signed({max_neg[DW], max_neg}))
            sat = max_neg[DW-1:0];
        else
            sat = scaled[DW-1:0];
    end

    // Register result, one cycle latency
    always @(posedge clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= {DW{1'b0}};
        end else begin
            out_valid <= in_valid;
            if (in_valid)
                out_data <= sat;
        end
    end

endmodule // chan0_correct
`default_nettype wire
